// [verilog/gpio_drive_and_pin_interrupts.sv]
// module: gpio drive selection, pin interrupts and serial pin placement with apb slave
`timescale 1ns/100ps
module gpio_drive_and_pin_interrupts
  import gpio_pkg::*;
#(
  parameter int port0_pins = 8,
  parameter int port1_pins = 3
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [port0_pins+port1_pins-1:0] pin_in,
  output logic [port0_pins+port1_pins-1:0] pin_out,
  output logic [port0_pins+port1_pins-1:0] pin_oe_n_out,
  output logic [port0_pins+port1_pins-1:0] pin_pullup_out,
  input wire logic twowire_scl_drive_low_in,
  input wire logic twowire_sda_drive_low_in,
  output logic twowire_scl_out,
  output logic twowire_sda_out,
  output logic irq_out
);
  localparam int npins = port0_pins + port1_pins;

  initial
  begin
    // port 1 reset value is only three bits wide, and the serial pins need two
    if (port0_pins != 8 || port1_pins < 2 || port1_pins > 3)
      $error("port widths unsupported");
  end

  // ************************************
  // state
  // ************************************
  typedef struct packed
  {
    logic [7:0] data0;
    logic [port1_pins-1:0] data1;
    logic [3:0] cfg;
    logic [7:0] irq_en0;
    logic [port1_pins-1:0] irq_en1;
    logic [7:0] place;
    logic [2:0] ctrl;
    logic [npins-1:0] status;
    logic [npins-1:0] mask;
    logic [31:0] rdata;
  } regs_t;
  regs_t st_reg;
  regs_t st_next;

  logic [npins-1:0] level;
  logic [npins-1:0] rise;
  logic [npins-1:0] fall;
  logic [npins-1:0] data_all;
  logic [npins-1:0] en_all;
  logic [npins-1:0] edge_hit;
  logic [npins-1:0] serial_pin;
  logic wr;
  logic rd;

  function automatic logic [1:0] port_cfg(input logic [3:0] cfg, input int idx);
    port_cfg = (idx < port0_pins) ? cfg[1:0] : cfg[3:2];
  endfunction

  pin_edge_sync #(.width(npins)) u_sync
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(pin_in),
    .level_out(level),
    .rise_out(rise),
    .fall_out(fall)
  );

  assign data_all = {st_reg.data1, st_reg.data0};
  assign en_all = {st_reg.irq_en1, st_reg.irq_en0};
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && !penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out = st_reg.rdata;

  // location and width select both zero: scl on p1.0, sda on p1.1
  always_comb
  begin
    serial_pin = '0;
    if (st_reg.ctrl[ctrl_twowire_bit] && !st_reg.place[serial_pos_bit]
        && !st_reg.place[serial_width_bit])
    begin
      serial_pin[port0_pins] = 1'b1;
      serial_pin[port0_pins+1] = 1'b1;
    end
  end

  // ************************************
  // pin drivers
  // ************************************
  genvar g;
  generate
    for (g = 0; g < npins; g++)
    begin : g_pin
      logic [1:0] c;
      logic d;
      assign c = port_cfg(st_reg.cfg, g);
      // serial pins: open drain from data bit and two-wire engine
      assign d = serial_pin[g]
        ? (data_all[g] && !(g == port0_pins ? twowire_scl_drive_low_in
                                            : twowire_sda_drive_low_in))
        : data_all[g];
      assign pin_out[g] = serial_pin[g] ? 1'b0 : d;
      always_comb
      begin
        if (!d)
          pin_oe_n_out[g] = 1'b0;
        else if (serial_pin[g])
          pin_oe_n_out[g] = 1'b1;
        else if (c == cfg_strong)
          pin_oe_n_out[g] = 1'b0;
        else
          pin_oe_n_out[g] = 1'b1;
      end
      // pull-up off in two-wire use; the bus needs external pull-ups
      assign pin_pullup_out[g] = d && !serial_pin[g] && c == cfg_resistive;
      // falling edge for 01/11, rising for 00, none when driven
      assign edge_hit[g] = (c == cfg_rise_hiz) ? rise[g]
        : (c == cfg_strong) ? 1'b0 : fall[g];
    end
  endgenerate

  assign twowire_scl_out = level[port0_pins];
  assign twowire_sda_out = level[port0_pins+1];

  // ************************************
  // registers
  // ************************************
  always_comb
  begin
    st_next = st_reg;
    // edges latch pending bits; a set beats a same-cycle clear
    if (wr && paddr_in == irq_status_off)
      st_next.status = st_reg.status & ~pwdata_in[npins-1:0];
    st_next.status = st_next.status | (edge_hit & en_all
      & {npins{st_reg.ctrl[ctrl_global_bit] & st_reg.ctrl[ctrl_sense_bit]}});
    if (wr)
    begin
      case (paddr_in)
        port0_data_off: st_next.data0 = pwdata_in[7:0];
        port1_data_off: st_next.data1 = pwdata_in[port1_pins-1:0];
        port_cfg_off: st_next.cfg = pwdata_in[3:0];
        port0_irq_en_off: st_next.irq_en0 = pwdata_in[7:0];
        port1_irq_en_off: st_next.irq_en1 = pwdata_in[port1_pins-1:0];
        serial_place_off: st_next.place = pwdata_in[7:0];
        irq_ctrl_off: st_next.ctrl = pwdata_in[2:0];
        irq_mask_off: st_next.mask = pwdata_in[npins-1:0];
        default: st_next.rdata = st_reg.rdata;
      endcase
    end
    if (rd)
    begin
      // enable registers are write-only and read back as zero
      case (paddr_in)
        port0_data_off: st_next.rdata = {24'h0, level[7:0]};
        port1_data_off: st_next.rdata = 32'({level[npins-1:port0_pins]});
        port_cfg_off: st_next.rdata = {28'h0, st_reg.cfg};
        serial_place_off: st_next.rdata = {24'h0, st_reg.place};
        pin_state_off: st_next.rdata = 32'(level);
        irq_ctrl_off: st_next.rdata = {29'h0, st_reg.ctrl};
        irq_status_off: st_next.rdata = 32'(st_reg.status);
        irq_mask_off: st_next.rdata = 32'(st_reg.mask);
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_reg <= '0;
      st_reg.data0 <= port0_data_rst;
      st_reg.data1 <= port1_data_rst[port1_pins-1:0];
      st_reg.cfg <= port_cfg_rst;
      st_reg.irq_en0 <= irq_en_rst;
      st_reg.irq_en1 <= irq_en_rst[port1_pins-1:0];
      st_reg.place <= serial_place_rst;
    end
    else
      st_reg <= st_next;
  end

  assign irq_out = |(st_reg.status & st_reg.mask);

  // ************************************
  // checks
  // ************************************
  chk_low_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!data_all[0] |-> !pin_oe_n_out[0] && !pin_out[0])) else $error("zero data not driven low");
  chk_strong_high: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (data_all[1] && st_reg.cfg[1:0] == cfg_strong |-> !pin_oe_n_out[1] && pin_out[1]))
    else $error("strong high missing");
  chk_weak_pull: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (data_all[2] && st_reg.cfg[1:0] == cfg_resistive |-> pin_oe_n_out[2] && pin_pullup_out[2]))
    else $error("resistive mode wrong");
  chk_hiz_mode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (data_all[3] && !st_reg.cfg[1] |-> pin_oe_n_out[3] && !pin_pullup_out[3]))
    else $error("hi-z mode wrong");
  chk_enable_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wr && paddr_in == port0_irq_en_off |=> st_reg.irq_en0 == $past(pwdata_in[7:0])))
    else $error("enable write lost");
  chk_serial_odrain: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (serial_pin[port0_pins] |-> !pin_out[port0_pins] && !pin_pullup_out[port0_pins]))
    else $error("serial pin not open drain");
  chk_driven_noirq: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_reg.cfg[1:0] == cfg_strong && $stable(st_reg.cfg) && !wr |=> $stable(st_reg.status[0])))
    else $error("driven pin raised irq");
  chk_edge_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (fall[0] && en_all[0] && st_reg.cfg[1:0] == cfg_fall_hiz && st_reg.ctrl[0] && st_reg.ctrl[1]
     |=> st_reg.status[0])) else $error("edge not latched");
endmodule

// [verilog/gpio_pkg.sv]
// package: register map, field layout and reset values of the gpio drive block
package gpio_pkg;
  // register indices; each register sits on its own aligned word, byte address = 4 x index
  localparam logic [7:0] port0_data_idx = 8'h00;
  localparam logic [7:0] port1_data_idx = 8'h01;
  localparam logic [7:0] port0_irq_en_idx = 8'h04;
  localparam logic [7:0] port1_irq_en_idx = 8'h05;
  localparam logic [7:0] port0_data_off = {port0_data_idx[5:0], 2'h0};
  localparam logic [7:0] port1_data_off = {port1_data_idx[5:0], 2'h0};
  localparam logic [7:0] port_cfg_off = 8'h08;
  localparam logic [7:0] port0_irq_en_off = {port0_irq_en_idx[5:0], 2'h0};
  localparam logic [7:0] port1_irq_en_off = {port1_irq_en_idx[5:0], 2'h0};
  localparam logic [7:0] serial_place_off = 8'h18;
  localparam logic [7:0] pin_state_off = 8'h1c;
  localparam logic [7:0] irq_ctrl_off = 8'h20;
  localparam logic [7:0] irq_status_off = 8'h24;
  localparam logic [7:0] irq_mask_off = 8'h28;
  localparam logic [7:0] port0_data_rst = 8'hff;
  localparam logic [2:0] port1_data_rst = 3'h7;
  localparam logic [3:0] port_cfg_rst = 4'h0;
  localparam logic [7:0] irq_en_rst = 8'h00;
  localparam logic [7:0] serial_place_rst = 8'h00;
  localparam int serial_pos_bit = 7;
  localparam int serial_width_bit = 1;
  localparam int ctrl_global_bit = 0;
  localparam int ctrl_sense_bit = 1;
  localparam int ctrl_twowire_bit = 2;
  localparam logic [1:0] cfg_rise_hiz = 2'h0;
  localparam logic [1:0] cfg_fall_hiz = 2'h1;
  localparam logic [1:0] cfg_strong = 2'h2;
  localparam logic [1:0] cfg_resistive = 2'h3;
  localparam int sync_stages = 2;
endpackage

// [verilog/pin_edge_sync.sv]
// module: two-flop pin synchroniser with rise and fall pulses
`timescale 1ns/100ps
module pin_edge_sync
  import gpio_pkg::*;
#(
  parameter int width = 11
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] level_out,
  output logic [width-1:0] rise_out,
  output logic [width-1:0] fall_out
);
  typedef struct packed
  {
    logic [width-1:0] meta;
    logic [width-1:0] sync;
    logic [width-1:0] last;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  initial
  begin
    if (width < 1) $error("width must be positive");
    if (sync_stages != 2) $error("only two synchroniser stages supported");
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.meta = pin_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
  end

  // reset state is idle-high so a pulled-up pin makes no edge at release
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st_reg <= '1;
    else
      st_reg <= st_next;
  end

  assign level_out = st_reg.sync;
  assign rise_out = st_reg.sync & ~st_reg.last;
  assign fall_out = ~st_reg.sync & st_reg.last;
endmodule

// [tb/pin_partner.sv]
// pin partner: external circuits that sit on the gpio pins
`timescale 1ns/100ps
module pin_partner
(
  input wire logic clk_in,
  input wire logic [10:0] drive_in,
  input wire logic [10:0] oe_n_in,
  input wire logic [10:0] pullup_in,
  input wire logic [10:0] ext_en_in,
  input wire logic [10:0] ext_val_in,
  output logic [10:0] level_out
);
  logic [10:0] wander = 11'h555;
  // a floating pin changes every cycle so a stale level never reads as valid
  always @(posedge clk_in)
    wander <= ~wander;
  // an external driver overrides the weak pull-up
  always_comb
    for (int i = 0; i < 11; i++)
      level_out[i] = !oe_n_in[i] ? drive_in[i] : ext_en_in[i] ? ext_val_in[i] :
        pullup_in[i] ? 1'b1 : wander[i];
endmodule

// [tb/tb.sv]
// testbench: drive modes, pin interrupts and serial pin placement over apb
`timescale 1ns/100ps
module tb;
  import gpio_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [10:0] pin_in;
  logic [10:0] pin_out;
  logic [10:0] pin_oe_n_out;
  logic [10:0] pin_pullup_out;
  logic twowire_scl_drive_low_in = 1'b0;
  logic twowire_sda_drive_low_in = 1'b0;
  logic twowire_scl_out;
  logic twowire_sda_out;
  logic irq_out;
  logic [10:0] ext_en = 11'h000;
  logic [10:0] ext_val = 11'h7ff;
  int err_count = 0;
  int checks_done = 0;
  always #4 clk_in = ~clk_in;
  gpio_drive_and_pin_interrupts i_gpio_drive_and_pin_interrupts (.clk_in, .rstn_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .pin_in, .pin_out, .pin_oe_n_out, .pin_pullup_out,
    .twowire_scl_drive_low_in, .twowire_sda_drive_low_in, .twowire_scl_out,
    .twowire_sda_out, .irq_out);
  pin_partner i_pin_partner (.clk_in, .drive_in(pin_out), .oe_n_in(pin_oe_n_out),
    .pullup_in(pin_pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pin_in));
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= is_wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    q = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // returns {oe_n, pullup, level}, level assuming the outside drives x on free pins
  function automatic logic [32:0] expect_pins(input logic [10:0] d, input logic [3:0] c,
    input logic [10:0] x);
    logic [1:0] m;
    logic [32:0] e;
    for (int i = 0; i < 11; i++)
    begin
      m = (i < 8) ? c[1:0] : c[3:2];
      e[22+i] = d[i] && (m != cfg_strong);
      e[11+i] = d[i] && (m == cfg_resistive);
      e[i] = e[22+i] ? x[i] : d[i];
    end
    return e;
  endfunction
  task automatic after_reset();
    rd(port_cfg_off, 32'h0);
    rd(serial_place_off, 32'h0);
    chk(32'(pin_oe_n_out), 32'h7ff);
    wr(irq_ctrl_off, 32'h3);
    wr(irq_mask_off, 32'h7ff);
    ext_val <= 11'h000;
    repeat (5) @(posedge clk_in);
    ext_val <= 11'h7ff;
    repeat (6) @(posedge clk_in);
    rd(irq_status_off, 32'h0);
  endtask
  task automatic irq_case(input logic [1:0] c, input logic [1:0] ctl, input logic [7:0] en,
    input logic [10:0] from, input logic [10:0] exp);
    wr(irq_ctrl_off, 32'(ctl));
    wr(port_cfg_off, 32'({c, c}));
    wr(port0_irq_en_off, 32'(en));
    ext_val <= from;
    repeat (6) @(posedge clk_in);
    wr(irq_status_off, 32'h7ff);
    ext_val <= ~from;
    repeat (6) @(posedge clk_in);
    rd(irq_status_off, 32'(exp));
    chk(32'(irq_out), 32'(exp != 11'h0));
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [10:0] d;
    logic [3:0] c;
    logic [32:0] e;
    logic [7:0] r;
    logic [10:0] rmask;
    void'($urandom(32'h90a9eff6));
    ext_en <= 11'h7ff;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    after_reset();
    rd(8'h3c, 32'h0);
    for (int k = 0; k < 24; k++)
    begin
      d = 11'($urandom);
      c = (k < 16) ? 4'(k) : 4'($urandom);
      ext_val <= 11'($urandom);
      // outside drivers may let go only where the pull-up keeps the pin defined
      rmask = {{3{c[3:2] == cfg_resistive}}, {8{c[1:0] == cfg_resistive}}};
      ext_en <= 11'($urandom) | ~rmask;
      wr(port0_data_off, 32'(d[7:0]));
      wr(port1_data_off, 32'(d[10:8]));
      wr(port_cfg_off, 32'(c));
      repeat (4) @(posedge clk_in);
      e = expect_pins(d, c, (ext_val & ext_en) | ~ext_en);
      chk(32'(pin_oe_n_out), 32'(e[32:22]));
      chk(32'(pin_pullup_out), 32'(e[21:11]));
      chk(32'(pin_out & ~pin_oe_n_out), 32'(d & ~e[32:22]));
      rd(port0_data_off, 32'(e[7:0]));
      rd(port1_data_off, 32'(e[10:8]));
    end
    ext_en <= 11'h7ff;
    wr(port0_data_off, 32'hff);
    wr(port1_data_off, 32'h7);
    wr(port1_irq_en_off, 32'h0);
    irq_case(2'h0, 2'h3, 8'h0f, 11'h000, 11'h00f);
    irq_case(2'h0, 2'h3, 8'hff, 11'h7ff, 11'h000);
    irq_case(2'h1, 2'h3, 8'hf1, 11'h7ff, 11'h0f1);
    irq_case(2'h3, 2'h3, 8'hff, 11'h7ff, 11'h0ff);
    irq_case(2'h2, 2'h3, 8'hff, 11'h7ff, 11'h000);
    // the device's own drive makes real edges while driven; still no pending bit
    wr(port0_data_off, 32'h00);
    repeat (6) @(posedge clk_in);
    wr(port0_data_off, 32'hff);
    repeat (6) @(posedge clk_in);
    rd(irq_status_off, 32'h0);
    irq_case(2'h0, 2'h1, 8'hff, 11'h000, 11'h000);
    irq_case(2'h0, 2'h2, 8'hff, 11'h000, 11'h000);
    r = 8'($urandom) | 8'h01;
    irq_case(2'h0, 2'h3, r, 11'h000, 11'(r));
    wr(irq_mask_off, 32'h0);
    repeat (2) @(posedge clk_in);
    chk(32'(irq_out), 32'h0);
    wr(irq_mask_off, 32'h7ff);
    repeat (2) @(posedge clk_in);
    chk(32'(irq_out), 32'h1);
    wr(irq_status_off, 32'h7ff);
    repeat (2) @(posedge clk_in);
    chk(32'(irq_out), 32'h0);
    wr(port_cfg_off, 32'hf);
    wr(irq_ctrl_off, 32'h4);
    for (int k = 0; k < 4; k++)
    begin
      twowire_scl_drive_low_in <= k[0];
      twowire_sda_drive_low_in <= k[1];
      repeat (4) @(posedge clk_in);
      chk({30'h0, pin_oe_n_out[9:8]}, {30'h0, ~k[1:0]});
      chk({30'h0, pin_pullup_out[9:8]}, 32'h0);
      chk({30'h0, pin_out[9:8] & ~pin_oe_n_out[9:8]}, 32'h0);
      chk({30'h0, twowire_sda_out, twowire_scl_out}, {30'h0, ~k[1:0]});
    end
    wr(serial_place_off, 32'h82);
    rd(serial_place_off, 32'h82);
    chk({30'h0, pin_pullup_out[9:8]}, 32'h3);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    after_reset();
    report_and_stop();
  end
  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule
